// file: rtl/uep_cfg.svh
// Purpose: Register offsets and field positions of the OUT endpoint engine.
// Assumes: APB byte addresses, 32-bit data, one register per aligned word.
// Notes:   Field positions are used by index; offsets compare to paddr.
//
// Overview of operation
// - Single bank busy with software: answer NAK.
// - Bank zero stored: set rx_bank0_full, interrupt pending.
// - Readable byte count of held data.
// - Stored payload read through FIFO data register.
// - Clearing bank flag returns bank to device.
// - Dual bank: first bank zero, next bank one.
// - Bank one sets rx_bank1_full; banks alternate.
// - Interrupt pending while either bank flag set.
// - force_stall_a set: answer OUT and IN transactions with STALL.
// - STALL sent sets stall_sent_b; software clears.
// - Endpoint reset clears FIFO pointers.
// - End of bus reset sets unmaskable flag, interrupt.
// - Bus reset clears mask and endpoint control.
// - IN packet acknowledged: set tx_complete, pending.
// - SETUP acknowledged, setup_received set, interrupt pending.
`ifndef UEP_CFG_SVH
`define UEP_CFG_SVH

`define UEP_OFF_GLB   12'h004
`define UEP_OFF_FADDR 12'h008
`define UEP_OFF_IER   12'h010
`define UEP_OFF_IDR   12'h014
`define UEP_OFF_IMR   12'h018
`define UEP_OFF_ISR   12'h01c
`define UEP_OFF_ICR   12'h020
`define UEP_OFF_RST   12'h028
`define UEP_OFF_CSR   12'h030
`define UEP_OFF_FDR   12'h050
`define UEP_OFF_TXVC  12'h074

`define UEP_CSR_TXC   0
`define UEP_CSR_RXB0  1
`define UEP_CSR_SETUP 2
`define UEP_CSR_STLS  3
`define UEP_CSR_TXRDY 4
`define UEP_CSR_FSTL  5
`define UEP_CSR_RXB1  6
`define UEP_CSR_TYPE  8
`define UEP_CSR_EN    15
`define UEP_CSR_CNT   16

`define UEP_INT_EP    0
`define UEP_INT_EBR   12
`define UEP_GLB_FADD  0
`define UEP_GLB_CONF  1
`define UEP_FA_FEN    8
`define UEP_TXV_DIS   8
`define UEP_RST_EP    0

`endif

// file: rtl/uep_pkg.sv
// Purpose: Shared types of the OUT endpoint engine.
// Assumes: Nothing beyond the cfg header.
// Notes:   One-hot state codes.
package uep_pkg;
  typedef enum logic [1:0] {
    UEP_ST_IDLE = 2'h1,
    UEP_ST_RECV = 2'h2
  } uep_state_type;

  typedef enum logic [1:0] {
    UEP_HS_ACK   = 2'h0,
    UEP_HS_NAK   = 2'h1,
    UEP_HS_STALL = 2'h2
  } uep_hs_type;
endpackage

// file: rtl/uep_ram_if.sv
// Purpose: Carrier between the endpoint engine and its bank memory.
// Assumes: Address is {bank, byte index}.
// Notes:   Read is combinational from ra.
`timescale 1ns/1ps
interface uep_ram_if #(parameter int AW = 6);
  logic          we;
  logic [AW:0]   wa;
  logic [7:0]    wd;
  logic [AW:0]   ra;
  logic [7:0]    rd;
  modport ctrl (output we, output wa, output wd, output ra, input rd);
  modport mem  (input we, input wa, input wd, input ra, output rd);
endinterface

// file: rtl/uep_bank_ram.sv
// Purpose: Two receive banks of byte storage.
// Assumes: Single clock, write on edge, read asynchronous.
// Notes:   Contents are not reset; pointers define what is valid.
`timescale 1ns/1ps
module uep_bank_ram #(
  parameter int AW = 6
) (
  input wire logic pclk,
  uep_ram_if.mem   ram
);
  logic [7:0] mem_reg [0:(2**(AW+1))-1];

  always_ff @(posedge pclk) begin
    if (ram.we) begin
      mem_reg[ram.wa] <= ram.wd;
    end
  end

  assign ram.rd = mem_reg[ram.ra];
endmodule

// file: rtl/uep_out_endpoint.sv
// Purpose: OUT endpoint engine with stall, bank flags and APB registers.
// Assumes: Link inputs come from packet logic on pclk, one-cycle pulses.
// Notes:   APB answers with one wait state; writes act at pready edge.
`timescale 1ns/1ps
`include "uep_cfg.svh"
module uep_out_endpoint #(
  parameter int DEPTH = 64,
  parameter bit DUAL  = 1'b1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lk_out_start,
  input  wire logic        lk_setup_start,
  input  wire logic        lk_in_token,
  input  wire logic        lk_in_ack,
  input  wire logic        lk_rx_valid,
  input  wire logic [7:0]  lk_rx_byte,
  input  wire logic        lk_rx_end,
  input  wire logic        lk_bus_reset_end,
  output logic             hs_valid,
  output logic      [1:0]  hs_code,
  output logic             irq
);
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;

  typedef struct packed {
    uep_pkg::uep_state_type state;
    logic                   pready;
    logic [31:0]            prdata;
    logic                   pslverr;
    logic                   hs_valid;
    uep_pkg::uep_hs_type    hs_code;
    logic                   irq;
    logic                   txc;
    logic                   bk0;
    logic                   bk1;
    logic                   setup;
    logic                   stls;
    logic                   txrdy;
    logic                   fstl;
    logic [2:0]             ep_type;
    logic                   ep_en;
    logic                   ep_ie;
    logic                   ebr;
    logic                   address_state_enable;
    logic                   confg;
    logic [6:0]             faddr;
    logic                   function_enable;
    logic                   txv_dis;
    logic                   rst_ep;
    logic                   wr_bank;
    logic                   rd_bank;
    logic                   acc;
    logic                   is_setup;
    logic                   stl_pend;
    logic [PW-1:0]          wr_ptr;
    logic [PW-1:0]          rd_ptr;
    logic [PW-1:0]          cnt0;
    logic [PW-1:0]          cnt1;
  } uep_st_type;

  uep_st_type    st_reg;
  uep_st_type    st_next;
  logic [31:0]   rd_val;
  logic [PW-1:0] cur_cnt;
  logic          ep_pend;
  logic          acc_ph;
  logic          done_ph;
  logic          busy_bank;
  logic          ram_we;

  uep_ram_if #(.AW(AW)) ram ();

  uep_bank_ram #(.AW(AW)) u_ram (
    .pclk (pclk),
    .ram  (ram.mem)
  );

  function automatic logic is_mapped(input logic [11:0] a);
    case (a)
      `UEP_OFF_GLB, `UEP_OFF_FADDR, `UEP_OFF_IER, `UEP_OFF_IDR,
      `UEP_OFF_IMR, `UEP_OFF_ISR, `UEP_OFF_ICR, `UEP_OFF_RST,
      `UEP_OFF_CSR, `UEP_OFF_FDR, `UEP_OFF_TXVC: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // Setup data always lands in bank zero, whatever the ping-pong pointer says
  assign ram.we    = ram_we;
  assign ram.wa    = {st_reg.wr_bank & ~st_reg.is_setup, st_reg.wr_ptr[AW-1:0]};
  assign ram.wd    = lk_rx_byte;
  assign ram.ra    = {st_reg.rd_bank, st_reg.rd_ptr[AW-1:0]};
  assign acc_ph    = psel & penable & ~st_reg.pready;
  assign done_ph   = psel & penable & st_reg.pready;
  assign cur_cnt   = (st_reg.rd_bank ? st_reg.cnt1 : st_reg.cnt0) - st_reg.rd_ptr;
  assign ep_pend   = st_reg.txc | st_reg.bk0 | st_reg.bk1 | st_reg.setup | st_reg.stls;
  assign busy_bank = st_reg.setup | (st_reg.wr_bank ? st_reg.bk1 : st_reg.bk0);

  always_comb begin
    rd_val = '0;
    case (paddr)
      `UEP_OFF_GLB: begin
        rd_val[`UEP_GLB_FADD] = st_reg.address_state_enable;
        rd_val[`UEP_GLB_CONF] = st_reg.confg;
      end
      `UEP_OFF_FADDR: begin
        rd_val[6:0]         = st_reg.faddr;
        rd_val[`UEP_FA_FEN] = st_reg.function_enable;
      end
      `UEP_OFF_IMR: rd_val[`UEP_INT_EP] = st_reg.ep_ie;
      `UEP_OFF_ISR: begin
        rd_val[`UEP_INT_EP]  = ep_pend;
        rd_val[`UEP_INT_EBR] = st_reg.ebr;
      end
      `UEP_OFF_RST: rd_val[`UEP_RST_EP] = st_reg.rst_ep;
      `UEP_OFF_CSR: begin
        rd_val[`UEP_CSR_TXC]           = st_reg.txc;
        rd_val[`UEP_CSR_RXB0]          = st_reg.bk0;
        rd_val[`UEP_CSR_SETUP]         = st_reg.setup;
        rd_val[`UEP_CSR_STLS]          = st_reg.stls;
        rd_val[`UEP_CSR_TXRDY]         = st_reg.txrdy;
        rd_val[`UEP_CSR_FSTL]          = st_reg.fstl;
        rd_val[`UEP_CSR_RXB1]          = st_reg.bk1;
        rd_val[`UEP_CSR_TYPE +: 3]     = st_reg.ep_type;
        rd_val[`UEP_CSR_EN]            = st_reg.ep_en;
        rd_val[`UEP_CSR_CNT +: PW]     = cur_cnt;
      end
      `UEP_OFF_FDR:  rd_val[7:0] = ram.rd;
      `UEP_OFF_TXVC: rd_val[`UEP_TXV_DIS] = st_reg.txv_dis;
      default:       rd_val = '0;
    endcase
  end

  always_comb begin
    st_next          = st_reg;
    ram_we           = 1'b0;
    st_next.hs_valid = 1'b0;
    st_next.pready   = 1'b0;
    st_next.pslverr  = 1'b0;
    if (acc_ph) begin
      st_next.pready  = 1'b1;
      st_next.pslverr = ~is_mapped(paddr);
      st_next.prdata  = rd_val;
    end
    if (done_ph && pwrite) begin
      case (paddr)
        `UEP_OFF_GLB: begin
          // Only a bus reset takes the device back out of address state
          if (pwdata[`UEP_GLB_FADD]) begin
            st_next.address_state_enable = 1'b1;
          end
          st_next.confg = pwdata[`UEP_GLB_CONF];
        end
        `UEP_OFF_FADDR: begin
          st_next.faddr = pwdata[6:0];
          st_next.function_enable   = pwdata[`UEP_FA_FEN];
        end
        `UEP_OFF_IER: if (pwdata[`UEP_INT_EP]) st_next.ep_ie = 1'b1;
        `UEP_OFF_IDR: if (pwdata[`UEP_INT_EP]) st_next.ep_ie = 1'b0;
        `UEP_OFF_ICR: if (pwdata[`UEP_INT_EBR]) st_next.ebr = 1'b0;
        `UEP_OFF_RST:  st_next.rst_ep  = pwdata[`UEP_RST_EP];
        `UEP_OFF_TXVC: st_next.txv_dis = pwdata[`UEP_TXV_DIS];
        `UEP_OFF_CSR: begin
          st_next.txrdy   = pwdata[`UEP_CSR_TXRDY];
          st_next.fstl    = pwdata[`UEP_CSR_FSTL];
          st_next.ep_type = pwdata[`UEP_CSR_TYPE +: 3];
          st_next.ep_en   = pwdata[`UEP_CSR_EN];
          // Device-set flags: writing zero clears, writing one keeps
          st_next.txc     = st_reg.txc & pwdata[`UEP_CSR_TXC];
          st_next.bk0     = st_reg.bk0 & pwdata[`UEP_CSR_RXB0];
          st_next.bk1     = st_reg.bk1 & pwdata[`UEP_CSR_RXB1];
          st_next.setup   = st_reg.setup & pwdata[`UEP_CSR_SETUP];
          st_next.stls    = st_reg.stls & pwdata[`UEP_CSR_STLS];
          // Order of two full banks is not visible; read side follows clears
          if (st_reg.bk0 && !pwdata[`UEP_CSR_RXB0]) begin
            st_next.rd_bank = DUAL;
            st_next.rd_ptr  = '0;
          end
          if (st_reg.bk1 && !pwdata[`UEP_CSR_RXB1]) begin
            st_next.rd_bank = 1'b0;
            st_next.rd_ptr  = '0;
          end
          if (st_reg.setup && !pwdata[`UEP_CSR_SETUP]) begin
            st_next.rd_ptr = '0;
          end
        end
        default: st_next.pslverr = 1'b0;
      endcase
    end
    if (done_ph && !pwrite && paddr == `UEP_OFF_FDR) begin
      st_next.rd_ptr = st_reg.rd_ptr + PW'(1);
    end
    if (st_next.rst_ep) begin
      st_next.wr_bank = 1'b0;
      st_next.rd_bank = 1'b0;
      st_next.wr_ptr  = '0;
      st_next.rd_ptr  = '0;
      st_next.cnt0    = '0;
      st_next.cnt1    = '0;
    end
    // Device events come after software writes so a set is never lost
    case (st_reg.state)
      uep_pkg::UEP_ST_IDLE: begin
        if (lk_setup_start) begin
          st_next.state    = uep_pkg::UEP_ST_RECV;
          st_next.acc      = 1'b1;
          st_next.is_setup = 1'b1;
          st_next.stl_pend = 1'b0;
          st_next.wr_ptr   = '0;
        end else if (lk_out_start) begin
          st_next.state    = uep_pkg::UEP_ST_RECV;
          st_next.is_setup = 1'b0;
          st_next.stl_pend = st_reg.fstl;
          st_next.acc      = st_reg.ep_en & ~st_reg.fstl & ~busy_bank;
          st_next.wr_ptr   = '0;
        end else if (lk_in_token && st_reg.fstl) begin
          st_next.hs_valid = 1'b1;
          st_next.hs_code  = uep_pkg::UEP_HS_STALL;
          st_next.stls     = 1'b1;
        end
        if (lk_in_ack) begin
          st_next.txc   = 1'b1;
          st_next.txrdy = 1'b0;
        end
      end
      uep_pkg::UEP_ST_RECV: begin
        // Bytes past the bank size are dropped rather than wrapped
        if (lk_rx_valid && st_reg.acc && st_reg.wr_ptr < DEPTH) begin
          ram_we         = 1'b1;
          st_next.wr_ptr = st_reg.wr_ptr + PW'(1);
        end
        if (lk_rx_end) begin
          st_next.state    = uep_pkg::UEP_ST_IDLE;
          st_next.hs_valid = 1'b1;
          if (st_reg.stl_pend) begin
            st_next.hs_code = uep_pkg::UEP_HS_STALL;
            st_next.stls    = 1'b1;
          end else if (st_reg.acc) begin
            st_next.hs_code = uep_pkg::UEP_HS_ACK;
            if (st_reg.is_setup) begin
              st_next.setup   = 1'b1;
              st_next.cnt0    = st_reg.wr_ptr;
              st_next.rd_bank = 1'b0;
            end else begin
              if (st_reg.wr_bank) begin
                st_next.bk1  = 1'b1;
                st_next.cnt1 = st_reg.wr_ptr;
              end else begin
                st_next.bk0  = 1'b1;
                st_next.cnt0 = st_reg.wr_ptr;
              end
              st_next.wr_bank = st_reg.wr_bank ^ DUAL;
            end
          end else begin
            st_next.hs_code = uep_pkg::UEP_HS_NAK;
          end
        end
      end
      default: st_next.state = uep_pkg::UEP_ST_IDLE;
    endcase
    if (lk_bus_reset_end) begin
      st_next.state    = uep_pkg::UEP_ST_IDLE;
      st_next.ebr      = 1'b1;
      st_next.ep_ie    = 1'b0;
      st_next.txc      = 1'b0;
      st_next.bk0      = 1'b0;
      st_next.bk1      = 1'b0;
      st_next.setup    = 1'b0;
      st_next.stls     = 1'b0;
      st_next.txrdy    = 1'b0;
      st_next.fstl     = 1'b0;
      st_next.ep_type  = '0;
      st_next.ep_en    = 1'b0;
      st_next.address_state_enable   = 1'b0;
      st_next.confg    = 1'b0;
      st_next.acc      = 1'b0;
      st_next.wr_bank  = 1'b0;
      st_next.rd_bank  = 1'b0;
      st_next.wr_ptr   = '0;
      st_next.rd_ptr   = '0;
      st_next.cnt0     = '0;
      st_next.cnt1     = '0;
    end
    // End of bus reset cannot be masked
    st_next.irq = st_next.ebr | (st_next.ep_ie & (st_next.txc | st_next.bk0 |
                  st_next.bk1 | st_next.setup | st_next.stls));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg       <= '0;
      st_reg.state <= uep_pkg::UEP_ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata   = st_reg.prdata;
  assign pready   = st_reg.pready;
  assign pslverr  = st_reg.pslverr;
  assign hs_valid = st_reg.hs_valid;
  assign hs_code  = st_reg.hs_code;
  assign irq      = st_reg.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_busy_start;
    st_reg.state == uep_pkg::UEP_ST_IDLE && lk_out_start && !lk_setup_start &&
      busy_bank && !lk_bus_reset_end;
  endsequence

  sequence s_pkt_end;
    st_reg.state == uep_pkg::UEP_ST_RECV && lk_rx_end && !lk_bus_reset_end;
  endsequence

  sequence s_fifo_pop;
    done_ph && !pwrite && paddr == `UEP_OFF_FDR && !st_next.rst_ep && !lk_bus_reset_end;
  endsequence

  a_busy_refused: assert property (
    s_busy_start |=> !st_reg.acc)
    else $error("Busy bank accepted a packet");

  a_nak_busy: assert property (
    s_pkt_end ##0 (!st_reg.acc && !st_reg.stl_pend) |=>
      hs_valid && hs_code == uep_pkg::UEP_HS_NAK)
    else $error("Refused packet not answered with NAK");

  a_bank0_count: assert property (
    s_pkt_end ##0 (st_reg.acc && !st_reg.is_setup && !st_reg.wr_bank &&
      !st_reg.stl_pend) |=> st_reg.bk0 && st_reg.cnt0 == $past(st_reg.wr_ptr))
    else $error("Bank zero flag or count wrong");

  a_bank_toggle: assert property (
    s_pkt_end ##0 (st_reg.acc && !st_reg.is_setup && !st_reg.stl_pend && DUAL &&
      !st_next.rst_ep) |=> st_reg.wr_bank != $past(st_reg.wr_bank))
    else $error("Bank pointer did not alternate");

  // Flags and irq register together, so a full bank must show in the same cycle
  a_irq_either: assert property (
    st_reg.ep_ie && (st_reg.bk0 || st_reg.bk1) |-> irq)
    else $error("Interrupt missing with a full bank");

  a_fifo_pop: assert property (
    s_fifo_pop |=> st_reg.rd_ptr == $past(st_reg.rd_ptr) + PW'(1))
    else $error("Data read did not advance pointer");

  a_stall_sent: assert property (
    s_pkt_end ##0 st_reg.stl_pend |=>
      hs_code == uep_pkg::UEP_HS_STALL && hs_valid && st_reg.stls)
    else $error("Stall not answered or not flagged");

  a_ebr_clears: assert property (
    lk_bus_reset_end |=> st_reg.ebr && !st_reg.ep_ie && !st_reg.ep_en && irq)
    else $error("Bus reset did not clear state");

  a_txc_set: assert property (
    st_reg.state == uep_pkg::UEP_ST_IDLE && lk_in_ack && !lk_bus_reset_end |=>
      st_reg.txc && !st_reg.txrdy)
    else $error("IN acknowledge did not set tx_complete");

  a_setup_ack: assert property (
    s_pkt_end ##0 st_reg.is_setup |=>
      hs_valid && hs_code == uep_pkg::UEP_HS_ACK && st_reg.setup)
    else $error("Setup not acknowledged");
endmodule

// file: verification/uep_host_model.sv
// Purpose: Host side of the link: token, data and handshake pulses on pclk.
// Assumes: Handshake answer arrives within a few cycles of the packet end.
// Notes:   A released data line shows the inverse byte, so stale data never matches.
`timescale 1ns/1ps
module uep_host_model (
  input  wire logic       pclk,
  input  wire logic       hs_valid,
  input  wire logic [1:0] hs_code,
  output logic            lk_out_start,
  output logic            lk_setup_start,
  output logic            lk_in_token,
  output logic            lk_in_ack,
  output logic            lk_rx_valid,
  output logic [7:0]      lk_rx_byte,
  output logic            lk_rx_end,
  output logic            lk_bus_reset_end
);
  initial begin
    {lk_out_start, lk_setup_start, lk_in_token, lk_in_ack} = 4'h0;
    {lk_rx_valid, lk_rx_end, lk_bus_reset_end} = 3'h0;
    lk_rx_byte = 8'h00;
  end

  // Code 3 means no handshake came back
  task automatic wait_hs(output logic [1:0] code);
    code = 2'h3;
    for (int w = 0; w < 20; w++) begin
      @(negedge pclk);
      if (hs_valid === 1'b1) begin
        code = hs_code;
        break;
      end
    end
  endtask

  // Token, then n bytes in order, then end; a second packet may follow at once
  task automatic packet(input bit setup, input int n, input logic [7:0] base,
                        output logic [1:0] code);
    @(posedge pclk);
    if (setup) lk_setup_start <= 1'b1;
    else lk_out_start <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      lk_out_start <= 1'b0;
      lk_setup_start <= 1'b0;
      lk_rx_valid <= 1'b1;
      lk_rx_byte <= base + 8'(i);
    end
    @(posedge pclk);
    lk_out_start <= 1'b0;
    lk_setup_start <= 1'b0;
    lk_rx_valid <= 1'b0;
    lk_rx_byte <= ~lk_rx_byte;
    lk_rx_end <= 1'b1;
    @(posedge pclk);
    lk_rx_end <= 1'b0;
    wait_hs(code);
  endtask

  // 0: IN token, 1: ACK of an IN packet, 2: end of bus reset
  task automatic pulse(input int which);
    @(posedge pclk);
    lk_in_token <= (which == 0);
    lk_in_ack <= (which == 1);
    lk_bus_reset_end <= (which == 2);
    @(posedge pclk);
    lk_in_token <= 1'b0;
    lk_in_ack <= 1'b0;
    lk_bus_reset_end <= 1'b0;
  endtask
endmodule

// file: verification/uep_out_endpoint_test.sv
// Purpose: Self-checking bench of the OUT endpoint engine over APB and link.
// Assumes: Dual-bank build, 64-byte banks.
// Notes:   APB answers are taken at the rising edge that ends the access; irq on the falling edge.
`timescale 1ns/1ps
`include "uep_cfg.svh"
module uep_out_endpoint_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, hs_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  hs_code;
  logic        lk_out_start, lk_setup_start, lk_in_token, lk_in_ack;
  logic        lk_rx_valid, lk_rx_end, lk_bus_reset_end;
  logic [7:0]  lk_rx_byte;
  int          num_errors, total_checks, cycles;

  uep_out_endpoint #(.DEPTH(64), .DUAL(1'b1)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lk_out_start(lk_out_start), .lk_setup_start(lk_setup_start),
    .lk_in_token(lk_in_token), .lk_in_ack(lk_in_ack), .lk_rx_valid(lk_rx_valid),
    .lk_rx_byte(lk_rx_byte), .lk_rx_end(lk_rx_end), .lk_bus_reset_end(lk_bus_reset_end),
    .hs_valid(hs_valid), .hs_code(hs_code), .irq(irq));

  uep_host_model host (
    .pclk(pclk), .hs_valid(hs_valid), .hs_code(hs_code), .lk_out_start(lk_out_start),
    .lk_setup_start(lk_setup_start), .lk_in_token(lk_in_token), .lk_in_ack(lk_in_ack),
    .lk_rx_valid(lk_rx_valid), .lk_rx_byte(lk_rx_byte), .lk_rx_end(lk_rx_end),
    .lk_bus_reset_end(lk_bus_reset_end));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Values read here are those the slave presents at this edge
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, a, d, rd, e);
  endtask

  task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, a, 32'h0, rd, e);
    chk(rd & m, exp);
  endtask

  task automatic pkt(input bit setup, input int n, input logic [7:0] b,
                     input logic [1:0] exp);
    logic [1:0] c;
    host.packet(setup, n, b, c);
    chk({30'h0, c}, {30'h0, exp});
  endtask

  task automatic irq_is(input logic exp);
    @(negedge pclk);
    @(negedge pclk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic t_regs();
    logic [31:0] rd;
    logic        e;
    rdm(`UEP_OFF_CSR, 32'hffffffff, 32'h0);
    apb(1'b0, 12'h00c, 32'h0, rd, e);
    chk({31'h0, e}, 32'h1);
    $display("test regs done");
  endtask

  task automatic t_dual();
    wr(`UEP_OFF_IER, 32'h1);
    wr(`UEP_OFF_CSR, 32'h0000_8200);
    pkt(0, 3, 8'h10, uep_pkg::UEP_HS_ACK);
    pkt(0, 2, 8'h20, uep_pkg::UEP_HS_ACK);
    pkt(0, 1, 8'h30, uep_pkg::UEP_HS_NAK);
    rdm(`UEP_OFF_CSR, 32'hffffffff, 32'h0003_8242);
    irq_is(1'b1);
    for (int i = 0; i < 3; i++) rdm(`UEP_OFF_FDR, 32'hff, 32'h10 + i);
    wr(`UEP_OFF_CSR, 32'h0000_824d);
    rdm(`UEP_OFF_CSR, 32'hffffffff, 32'h0002_8240);
    for (int i = 0; i < 2; i++) rdm(`UEP_OFF_FDR, 32'hff, 32'h20 + i);
    irq_is(1'b1);
    wr(`UEP_OFF_CSR, 32'h0000_820f);
    irq_is(1'b0);
    pkt(0, 1, 8'h40, uep_pkg::UEP_HS_ACK);
    rdm(`UEP_OFF_CSR, 32'hffffffff, 32'h0001_8202);
    rdm(`UEP_OFF_FDR, 32'hff, 32'h40);
    wr(`UEP_OFF_CSR, 32'h0000_824d);
    $display("test dual done");
  endtask

  task automatic t_stall();
    logic [1:0] c;
    wr(`UEP_OFF_CSR, 32'h0000_8220);
    pkt(0, 2, 8'h50, uep_pkg::UEP_HS_STALL);
    rdm(`UEP_OFF_CSR, 32'hffff, 32'h8228);
    irq_is(1'b1);
    wr(`UEP_OFF_CSR, 32'h0000_8220);
    irq_is(1'b0);
    host.pulse(0);
    host.wait_hs(c);
    chk({30'h0, c}, {30'h0, uep_pkg::UEP_HS_STALL});
    wr(`UEP_OFF_CSR, 32'h0000_8200);
    host.pulse(1);
    rdm(`UEP_OFF_CSR, 32'hffff, 32'h8201);
    wr(`UEP_OFF_CSR, 32'h0000_824e);
    $display("test stall done");
  endtask

  task automatic t_setup_rst();
    pkt(1, 8, 8'h60, uep_pkg::UEP_HS_ACK);
    rdm(`UEP_OFF_CSR, 32'hffffffff, 32'h0008_8204);
    irq_is(1'b1);
    rdm(`UEP_OFF_FDR, 32'hff, 32'h60);
    wr(`UEP_OFF_CSR, 32'h0000_8214);
    wr(`UEP_OFF_CSR, 32'h0000_8204);
    rdm(`UEP_OFF_CSR, 32'h10, 32'h0);
    wr(`UEP_OFF_CSR, 32'h0000_8214);
    rdm(`UEP_OFF_CSR, 32'h10, 32'h10);
    wr(`UEP_OFF_CSR, 32'h0000_8204);
    wr(`UEP_OFF_RST, 32'h1);
    rdm(`UEP_OFF_CSR, 32'hffff_0000, 32'h0);
    wr(`UEP_OFF_RST, 32'h0);
    $display("test setup and endpoint reset done");
  endtask

  task automatic t_bus_reset();
    wr(`UEP_OFF_TXVC, 32'h100);
    host.pulse(2);
    rdm(`UEP_OFF_ISR, 32'h1000, 32'h1000);
    rdm(`UEP_OFF_TXVC, 32'h100, 32'h100);
    rdm(`UEP_OFF_IMR, 32'h1, 32'h0);
    rdm(`UEP_OFF_CSR, 32'hffffffff, 32'h0);
    irq_is(1'b1);
    wr(`UEP_OFF_ICR, 32'h1000);
    irq_is(1'b0);
    pkt(0, 1, 8'h70, uep_pkg::UEP_HS_NAK);
    wr(`UEP_OFF_CSR, 32'h0000_8000);
    wr(`UEP_OFF_IER, 32'h1);
    wr(`UEP_OFF_TXVC, 32'h0);
    rdm(`UEP_OFF_TXVC, 32'h100, 32'h0);
    host.pulse(1);
    rdm(`UEP_OFF_CSR, 32'h1, 32'h1);
    wr(`UEP_OFF_CSR, 32'h0000_8000);
    wr(`UEP_OFF_GLB, 32'h1);
    wr(`UEP_OFF_FADDR, 32'h105);
    rdm(`UEP_OFF_FADDR, 32'h17f, 32'h105);
    wr(`UEP_OFF_GLB, 32'h3);
    wr(`UEP_OFF_CSR, 32'h0000_8200);
    rdm(`UEP_OFF_GLB, 32'h3, 32'h3);
    pkt(0, 1, 8'h71, uep_pkg::UEP_HS_ACK);
    $display("test bus reset done");
  endtask

  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    num_errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_dual();
    t_stall();
    t_setup_rst();
    t_bus_reset();
    final_report();
  end
endmodule
